// *** common/p1m_consts.svh ***
// register offsets, reset values and field values for the port 1 pin mux
`ifndef P1M_CONSTS_SVH
`define P1M_CONSTS_SVH
`define P1M_OFF_DATA 12'h000
`define P1M_OFF_DIR 12'h004
`define P1M_OFF_PULLUP 12'h008
`define P1M_OFF_FSEL 12'h00c
`define P1M_OFF_TFSEL 12'h010
`define P1M_OFF_TCSEL 12'h014
`define P1M_OFF_EDGE 12'h018
`define P1M_OFF_PIN 12'h01c
`define P1M_RST_BYTE 8'h00
`define P1M_RST_SEL 3'h0
`define P1M_DIR_READ 8'hff
`define P1M_TC_EVENT_SEL 3'h7
`define P1M_RESP_OKAY 2'h0
`define P1M_RESP_SLVERR 2'h2
`endif

// *** common/p1m_pkg.sv ***
// types for the port 1 pin mux
package p1m_pkg;
  typedef logic [7:0] p1m_byte_t;
  typedef logic [2:0] p1m_sel_t;
  typedef logic [1:0] p1m_resp_t;
endpackage

// *** hw/p1m_sync.sv ***
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module p1m_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [WIDTH-1:0] nxt_out;

  // output changes only where second and third stage agree
  always_comb begin
    nxt_out = (~(s2_ff ^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & out_ff);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_out = out_ff;
endmodule

// *** hw/p1m_top.sv ***
// port 1 pin function multiplexer with axi4-lite register slave
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "p1m_consts.svh"

module p1m_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [7:0] pin_pullup,
  // peripheral outputs routed to pins
  input wire logic pwm_out,
  input wire logic timer_f_high_output,
  input wire logic timer_f_low_output,
  input wire logic divided_clock_output,
  // peripheral inputs taken from pins (edge pulses; timer G capture input is the pin level)
  output logic ext_int_three_select,
  output logic ext_int_two_select,
  output logic ext_int_one_select,
  output logic timer_f_event_input,
  output logic timer_c_event_input,
  output logic timer_b_event_input,
  output logic timer_g_capture_input,
  // timer B event enable from its own mode field
  input wire logic timer_b_event_enable
);
  import p1m_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  p1m_byte_t port1_data_ff, nxt_port1_data;
  p1m_byte_t port1_direction_ff, nxt_port1_direction;
  p1m_byte_t port1_pullup_ctrl_ff, nxt_port1_pullup_ctrl;
  p1m_byte_t port1_function_select_ff, nxt_port1_function_select;
  p1m_sel_t timer_f_clock_select_ff, nxt_timer_f_clock_select;
  p1m_sel_t timer_c_clock_select_ff, nxt_timer_c_clock_select;
  p1m_byte_t edge_rise_ff, nxt_edge_rise;

  // bus state
  logic aw_hold_ff, nxt_aw_hold;
  logic w_hold_ff, nxt_w_hold;
  logic [11:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic wstrb0_ff, nxt_wstrb0;
  logic bvalid_ff, nxt_bvalid;
  p1m_resp_t bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  p1m_resp_t rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;

  // pin sampling and edge state
  p1m_byte_t pin_sync;
  p1m_byte_t pin_prev_ff, nxt_pin_prev;
  p1m_byte_t pin_read;
  p1m_byte_t edge_hit;
  logic do_write;

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  p1m_sync #(.WIDTH(8)) p1m_sync_i (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
  assign do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;

  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_port1_data = port1_data_ff;
    nxt_port1_direction = port1_direction_ff;
    nxt_port1_pullup_ctrl = port1_pullup_ctrl_ff;
    nxt_port1_function_select = port1_function_select_ff;
    nxt_timer_f_clock_select = timer_f_clock_select_ff;
    nxt_timer_c_clock_select = timer_c_clock_select_ff;
    nxt_edge_rise = edge_rise_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_hold = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `P1M_RESP_OKAY;
      unique case ({awaddr_ff[11:2], 2'b00})
        `P1M_OFF_DATA: if (wstrb0_ff) nxt_port1_data = wdata_ff[7:0];
        `P1M_OFF_DIR: if (wstrb0_ff) nxt_port1_direction = wdata_ff[7:0];
        `P1M_OFF_PULLUP: if (wstrb0_ff) nxt_port1_pullup_ctrl = wdata_ff[7:0];
        `P1M_OFF_FSEL: if (wstrb0_ff) nxt_port1_function_select = wdata_ff[7:0];
        `P1M_OFF_TFSEL: if (wstrb0_ff) nxt_timer_f_clock_select = wdata_ff[2:0];
        `P1M_OFF_TCSEL: if (wstrb0_ff) nxt_timer_c_clock_select = wdata_ff[2:0];
        `P1M_OFF_EDGE: if (wstrb0_ff) nxt_edge_rise = wdata_ff[7:0];
        `P1M_OFF_PIN: nxt_bresp = `P1M_RESP_OKAY;
        default: nxt_bresp = `P1M_RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = ~rvalid_ff;

  // data read: outputs show the latch, inputs the pin
  assign pin_read = (port1_direction_ff & port1_data_ff) | (~port1_direction_ff & pin_sync);

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `P1M_RESP_OKAY;
      nxt_rdata = '0;
      unique case ({s_axi_araddr[11:2], 2'b00})
        `P1M_OFF_DATA: nxt_rdata[7:0] = pin_read;
        `P1M_OFF_DIR: nxt_rdata[7:0] = `P1M_DIR_READ;
        `P1M_OFF_PULLUP: nxt_rdata[7:0] = port1_pullup_ctrl_ff;
        `P1M_OFF_FSEL: nxt_rdata[7:0] = port1_function_select_ff;
        `P1M_OFF_TFSEL: nxt_rdata[2:0] = timer_f_clock_select_ff;
        `P1M_OFF_TCSEL: nxt_rdata[2:0] = timer_c_clock_select_ff;
        `P1M_OFF_EDGE: nxt_rdata[7:0] = edge_rise_ff;
        `P1M_OFF_PIN: nxt_rdata[7:0] = pin_sync;
        default: nxt_rresp = `P1M_RESP_SLVERR;
      endcase
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // edge detection on alternate inputs
  // ----------------------------------------------------------------
  always_comb begin
    nxt_pin_prev = pin_sync;
  end

  // edge polarity per pin: 1 rising, 0 falling
  assign edge_hit = (edge_rise_ff & pin_sync & ~pin_prev_ff) | (~edge_rise_ff & ~pin_sync & pin_prev_ff);

  assign ext_int_three_select = port1_function_select_ff[7] & edge_hit[7];
  // timer F event only when clock select top bit is clear
  assign timer_f_event_input = port1_function_select_ff[7] & ~timer_f_clock_select_ff[2] & edge_hit[7];
  assign ext_int_two_select = port1_function_select_ff[6] & edge_hit[6];
  assign timer_c_event_input = port1_function_select_ff[6] &
    (timer_c_clock_select_ff == `P1M_TC_EVENT_SEL) & edge_hit[6];
  assign ext_int_one_select = port1_function_select_ff[5] & edge_hit[5];
  assign timer_b_event_input = port1_function_select_ff[5] & timer_b_event_enable & edge_hit[5];
  assign timer_g_capture_input = port1_function_select_ff[3] & pin_sync[3];

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_comb begin
    // gpio default: direction and data rule the pin
    pin_out = port1_data_ff;
    pin_oe_n = ~port1_direction_ff;
    // pull-up only on inputs
    pin_pullup = port1_pullup_ctrl_ff & ~port1_direction_ff;
    // alternate inputs: pin released
    if (port1_function_select_ff[7]) begin
      pin_oe_n[7] = 1'b1;
      pin_out[7] = 1'b0;
    end
    if (port1_function_select_ff[6]) begin
      pin_oe_n[6] = 1'b1;
      pin_out[6] = 1'b0;
    end
    if (port1_function_select_ff[5]) begin
      pin_oe_n[5] = 1'b1;
      pin_out[5] = 1'b0;
    end
    if (port1_function_select_ff[3]) begin
      pin_oe_n[3] = 1'b1;
      pin_out[3] = 1'b0;
    end
    // alternate outputs override gpio
    if (port1_function_select_ff[4]) begin
      pin_oe_n[4] = 1'b0;
      pin_out[4] = pwm_out;
    end
    if (port1_function_select_ff[2]) begin
      pin_oe_n[2] = 1'b0;
      pin_out[2] = timer_f_high_output;
    end
    if (port1_function_select_ff[1]) begin
      pin_oe_n[1] = 1'b0;
      pin_out[1] = timer_f_low_output;
    end
    if (port1_function_select_ff[0]) begin
      pin_oe_n[0] = 1'b0;
      pin_out[0] = divided_clock_output;
    end
    // pull-up inactive on any pin owned by an alternate function
    pin_pullup = pin_pullup & ~port1_function_select_ff;
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      port1_data_ff <= `P1M_RST_BYTE;
      port1_direction_ff <= `P1M_RST_BYTE;
      port1_pullup_ctrl_ff <= `P1M_RST_BYTE;
      port1_function_select_ff <= `P1M_RST_BYTE;
      timer_f_clock_select_ff <= `P1M_RST_SEL;
      timer_c_clock_select_ff <= `P1M_RST_SEL;
      edge_rise_ff <= `P1M_RST_BYTE;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0000_0000;
      pin_prev_ff <= `P1M_RST_BYTE;
    end else begin
      port1_data_ff <= nxt_port1_data;
      port1_direction_ff <= nxt_port1_direction;
      port1_pullup_ctrl_ff <= nxt_port1_pullup_ctrl;
      port1_function_select_ff <= nxt_port1_function_select;
      timer_f_clock_select_ff <= nxt_timer_f_clock_select;
      timer_c_clock_select_ff <= nxt_timer_c_clock_select;
      edge_rise_ff <= nxt_edge_rise;
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb0_ff <= nxt_wstrb0;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      pin_prev_ff <= nxt_pin_prev;
    end
  end
endmodule

// *** testbench/p1m_top_chk.sv ***
// assertion checker for the port 1 pin mux
`timescale 1ns/1ps
module p1m_top_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pin_pullup,
  // peripheral side
  input wire logic timer_b_event_enable,
  input wire logic ext_int_three_select,
  input wire logic ext_int_two_select,
  input wire logic ext_int_one_select,
  input wire logic timer_f_event_input,
  input wire logic timer_c_event_input,
  input wire logic timer_b_event_input,
  input wire logic timer_g_capture_input
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence r_done;
    s_axi_rvalid && s_axi_rready;
  endsequence
  a_pull_input: assert property ((pin_pullup & ~pin_oe_n) == 8'h00)
    else $error("pull-up on a driven pin");
  a_tf_gated: assert property (timer_f_event_input |-> ext_int_three_select)
    else $error("timer f event without int3 pulse");
  a_tc_gated: assert property (timer_c_event_input |-> ext_int_two_select)
    else $error("timer c event without int2 pulse");
  a_tb_gated: assert property (timer_b_event_input |-> ext_int_one_select && timer_b_event_enable)
    else $error("timer b event not gated");
  a_int3_pulse: assert property (ext_int_three_select |=> !ext_int_three_select)
    else $error("int3 pulse longer than one cycle");
  a_int3_undriven: assert property (ext_int_three_select |-> pin_oe_n[7] && !pin_out[7])
    else $error("pin 7 driven while an input");
  a_capture_undriven: assert property (timer_g_capture_input |-> pin_oe_n[3] && !pin_out[3])
    else $error("pin 3 driven while capture input");
  a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels open during response");
  a_b_retire: assert property (b_done |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_retire: assert property (r_done |=> !s_axi_rvalid && s_axi_arready)
    else $error("read response repeated");
endmodule

bind p1m_top p1m_top_chk p1m_top_chk_i (
  .core_clk(core_clk),
  .rst(rst),
  .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .pin_out(pin_out),
  .pin_oe_n(pin_oe_n),
  .pin_pullup(pin_pullup),
  .timer_b_event_enable(timer_b_event_enable),
  .ext_int_three_select(ext_int_three_select),
  .ext_int_two_select(ext_int_two_select),
  .ext_int_one_select(ext_int_one_select),
  .timer_f_event_input(timer_f_event_input),
  .timer_c_event_input(timer_c_event_input),
  .timer_b_event_input(timer_b_event_input),
  .timer_g_capture_input(timer_g_capture_input)
);

// *** testbench/p1m_top_tb_top.sv ***
// self-checking bench for the port 1 pin mux
`timescale 1ns/1ps
`include "p1m_consts.svh"
module p1m_top_tb_top;
  import p1m_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  p1m_resp_t s_axi_bresp, s_axi_rresp, r;
  p1m_byte_t pin_in = 8'h00, pin_out, pin_oe_n, pin_pullup;
  logic pwm_out = 1'b0, timer_f_high_output = 1'b0, timer_f_low_output = 1'b0, divided_clock_output = 1'b0;
  logic timer_b_event_enable = 1'b1;
  logic ext_int_three_select, ext_int_two_select, ext_int_one_select;
  logic timer_f_event_input, timer_c_event_input, timer_b_event_input, timer_g_capture_input;
  logic [31:0] d;
  logic [23:0] pcnt = 24'h0;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  p1m_top p1m_top_i (
    .core_clk(core_clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup),
    .pwm_out(pwm_out),
    .timer_f_high_output(timer_f_high_output),
    .timer_f_low_output(timer_f_low_output),
    .divided_clock_output(divided_clock_output),
    .ext_int_three_select(ext_int_three_select),
    .ext_int_two_select(ext_int_two_select),
    .ext_int_one_select(ext_int_one_select),
    .timer_f_event_input(timer_f_event_input),
    .timer_c_event_input(timer_c_event_input),
    .timer_b_event_input(timer_b_event_input),
    .timer_g_capture_input(timer_g_capture_input),
    .timer_b_event_enable(timer_b_event_enable)
  );
  always #5 core_clk = ~core_clk;
  // ----------------------------------------
  // pulse counters, one nibble per edge-pulse output (capture input not counted)
  // ----------------------------------------
  always @(negedge core_clk) begin
    if (!rst) begin
      pcnt[23:20] <= pcnt[23:20] + 4'(ext_int_three_select);
      pcnt[19:16] <= pcnt[19:16] + 4'(ext_int_two_select);
      pcnt[15:12] <= pcnt[15:12] + 4'(ext_int_one_select);
      pcnt[11:8] <= pcnt[11:8] + 4'(timer_f_event_input);
      pcnt[7:4] <= pcnt[7:4] + 4'(timer_c_event_input);
      pcnt[3:0] <= pcnt[3:0] + 4'(timer_b_event_input);
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input p1m_byte_t v);
    logic ta, tw, got;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(negedge core_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      got = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic axi_rd(input logic [11:0] a);
    logic ta, got;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(negedge core_clk);
      ta = s_axi_arvalid & s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
  endtask
  task automatic wr(input logic [11:0] a, input p1m_byte_t v);
    axi_wr(a, v);
    cmp(r, `P1M_RESP_OKAY);
  endtask
  task automatic rd_chk(input logic [11:0] a, input p1m_byte_t e);
    axi_rd(a);
    cmp(r, `P1M_RESP_OKAY);
    cmp(d, {24'h0, e});
  endtask
  task automatic pins(input p1m_byte_t x);
    @(posedge core_clk);
    pin_in <= x;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    cmp(pin_oe_n, 8'hff);
    rd_chk(`P1M_OFF_FSEL, `P1M_RST_BYTE);
    rd_chk(`P1M_OFF_DIR, `P1M_DIR_READ);
    rd_chk(`P1M_OFF_PULLUP, `P1M_RST_BYTE);
    axi_rd(12'h020);
    cmp(r, `P1M_RESP_SLVERR);
    cmp(d, 32'h0);
    axi_wr(12'h020, 8'hff);
    cmp(r, `P1M_RESP_SLVERR);
    s_axi_wstrb <= 4'he;
    wr(`P1M_OFF_PULLUP, 8'hff);
    s_axi_wstrb <= 4'hf;
    rd_chk(`P1M_OFF_PULLUP, `P1M_RST_BYTE);
    wr(`P1M_OFF_DIR, 8'hff);
    wr(`P1M_OFF_DATA, 8'ha5);
    cmp(pin_out, 8'ha5);
    cmp(pin_oe_n, 8'h00);
    rd_chk(`P1M_OFF_DATA, 8'ha5);
    wr(`P1M_OFF_DIR, 8'h0f);
    wr(`P1M_OFF_PULLUP, 8'hff);
    pins(8'h3c);
    rd_chk(`P1M_OFF_DATA, 8'h35);
    wr(`P1M_OFF_PIN, 8'hff);
    rd_chk(`P1M_OFF_PIN, 8'h3c);
    cmp(pin_pullup, 8'hf0);
    cmp(pin_oe_n, 8'hf0);
    wr(`P1M_OFF_DIR, 8'hff);
    wr(`P1M_OFF_DATA, 8'h00);
    wr(`P1M_OFF_FSEL, 8'h17);
    pins(8'h00);
    for (int v = 1; v >= 0; v--) begin
      @(posedge core_clk);
      pwm_out <= v[0];
      timer_f_high_output <= ~v[0];
      timer_f_low_output <= v[0];
      divided_clock_output <= ~v[0];
      @(negedge core_clk);
      cmp(pin_out, {3'h0, v[0], 1'b0, ~v[0], v[0], ~v[0]});
      cmp(pin_oe_n, 8'h00);
      cmp(pin_pullup, 8'h00);
    end
    wr(`P1M_OFF_TFSEL, 8'h00);
    wr(`P1M_OFF_TCSEL, 8'h07);
    rd_chk(`P1M_OFF_TCSEL, 8'h07);
    wr(`P1M_OFF_FSEL, 8'he8);
    cmp(pin_oe_n, 8'he8);
    pins(8'he8);
    cmp(pcnt, 24'h000000);
    cmp(timer_g_capture_input, 1'b1);
    pins(8'h00);
    cmp(pcnt, 24'h111111);
    wr(`P1M_OFF_EDGE, 8'he0);
    rd_chk(`P1M_OFF_EDGE, 8'he0);
    wr(`P1M_OFF_TFSEL, 8'h04);
    wr(`P1M_OFF_TCSEL, 8'h06);
    timer_b_event_enable <= 1'b0;
    pins(8'he0);
    cmp(pcnt, 24'h222111);
    wr(`P1M_OFF_FSEL, 8'h00);
    pins(8'h00);
    pins(8'h80);
    cmp(pcnt, 24'h222111);
    cmp(pin_oe_n, 8'h00);
    end_of_test();
  end
endmodule
